/* File: rtl/bufcr_pkg.sv */
/*
  bufcr_pkg: types and constants shared by the buffer command/response block.
  Assumes one clock domain; the protocol engine and the host command source
  sit on the same clock as the block.
*/
package bufcr_pkg;

  // command type byte codes, low three bits
  localparam logic [2:0] BA_RX = 3'h0;
  localparam logic [2:0] BA_TX = 3'h4;
  // response type codes, low three bits of the command type byte
  localparam logic [2:0] DISP_RX_DONE = 3'h0;
  localparam logic [2:0] DISP_RX_UNUSED = 3'h3;
  localparam logic [2:0] DISP_TX_DONE = 3'h4;
  localparam logic [2:0] DISP_TX_NOACK = 3'h6;
  localparam logic [2:0] DISP_TX_NOTSENT = 3'h7;
  localparam logic [2:0] RESP_CTRL = 3'h1;
  localparam logic [2:0] RESP_INFO = 3'h2;
  // octal code byte values
  localparam logic [7:0] CODE_TX_THRESH = 8'h04;
  localparam logic [7:0] CODE_START_RUN = 8'h08;
  localparam logic [7:0] CODE_MAINT_RUN = 8'h0a;
  localparam logic [7:0] CODE_PROC_ERR = 8'h3e;
  localparam logic [7:0] CODE_POOL_DONE = 8'h40;
  // unacknowledged transmissions before the threshold report
  localparam logic [2:0] RETRY_LIMIT = 3'h7;
  // reset values
  localparam logic EXT22_RST = 1'b0;

  typedef enum logic [1:0] {
    CMD_BUF = 2'b00,
    CMD_HALT = 2'b01,
    CMD_START = 2'b10,
    CMD_POOL = 2'b11
  } bufcr_cmd_kind_t;

  typedef enum logic [2:0] {
    EV_RX_DONE = 3'b000,
    EV_TX_START = 3'b001,
    EV_TX_ACK = 3'b010,
    EV_TX_NOACK = 3'b011,
    EV_START_RUN = 3'b100,
    EV_MAINT = 3'b101
  } bufcr_ev_kind_t;

  typedef struct packed {
    bufcr_cmd_kind_t kind;
    logic [7:0] command_type_byte;
    logic [7:0] tributary_address_byte;
    logic [15:0] low_address_word;
    logic [15:0] count_word;
    logic [7:0] high_address_byte;
    logic ext22;
    logic pool_en;
  } bufcr_cmd_t;

  typedef struct packed {
    bufcr_ev_kind_t kind;
    logic [7:0] trib;
    logic [13:0] count;
  } bufcr_ev_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [13:0] count;
  } bufcr_desc_t;

  typedef struct packed {
    logic [7:0] command_type_byte;
    logic [7:0] tributary_address_byte;
    logic [15:0] low_address_word;
    logic [15:0] count_word;
    logic [7:0] high_address_byte;
    logic [15:0] extended_count_word;
    logic [7:0] extended_code_byte;
  } bufcr_resp_t;

endpackage : bufcr_pkg

/* File: rtl/bufcr_core.sv */
/*
  bufcr_core: buffer assignment, queueing and return with disposition,
  control and information responses.
  Assumes host commands and protocol events arrive on ref_clk with
  valid/ready; one response register drains through resp_ready.
*/
module bufcr_core #(
  parameter int NTRIB = 4,
  parameter int DEPTH = 4,
  parameter int POOL_DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // mode
  input wire logic multipoint,
  // host commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bufcr_pkg::bufcr_cmd_t cmd,
  // protocol engine events
  input wire logic ev_valid,
  output logic ev_ready,
  input wire bufcr_pkg::bufcr_ev_t ev,
  // responses
  output logic resp_valid,
  input wire logic resp_ready,
  output bufcr_pkg::bufcr_resp_t resp,
  // status
  output logic ext22_mode
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = $clog2(POOL_DEPTH);
  localparam int IW = (NTRIB > 1) ? $clog2(NTRIB) : 1;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_TX = 3'b010,
    S_POOL = 3'b011,
    S_DONE = 3'b100
  } bufcr_state_t;

  bufcr_state_t state_r, state_nxt;
  bufcr_pkg::bufcr_desc_t rx_mem_r [NTRIB][DEPTH];
  bufcr_pkg::bufcr_desc_t tx_mem_r [NTRIB][DEPTH];
  bufcr_pkg::bufcr_desc_t pool_mem_r [POOL_DEPTH];
  logic [AW-1:0] rx_head_r [NTRIB];
  logic [AW:0] rx_cnt_r [NTRIB];
  logic [AW-1:0] tx_head_r [NTRIB];
  logic [AW:0] tx_cnt_r [NTRIB];
  logic [PW-1:0] pool_head_r;
  logic [PW:0] pool_cnt_r;
  logic [NTRIB-1:0] run_r, pool_en_r, sent_r;
  logic [2:0] retry_r [NTRIB];
  logic [IW-1:0] halt_idx_r;
  logic ext22_r;
  logic resp_valid_r;
  bufcr_pkg::bufcr_resp_t resp_r, resp_nxt;

  logic slot_free, take_cmd, take_ev, load;
  logic push_rx, push_tx, push_pool, pop_rx, pop_tx, pop_pool;
  logic set_sent, clr_sent, retry_inc, retry_clr, halt_go, set_run;
  logic [IW-1:0] idx, pidx;
  logic [7:0] trib;
  logic trib_ok;
  bufcr_pkg::bufcr_desc_t cmd_desc;

  // build a disposition response
  function automatic bufcr_pkg::bufcr_resp_t disp(input logic [2:0] code,
      input logic [7:0] tb, input bufcr_pkg::bufcr_desc_t d, input logic ext,
      input logic mp);
    bufcr_pkg::bufcr_resp_t r;
    r = '0;
    r.command_type_byte = {5'h00, code};
    r.tributary_address_byte = mp ? tb : 8'h01;
    r.low_address_word = d.addr[15:0];
    if (ext)
    begin
      r.high_address_byte = {2'h0, d.addr[21:16]};
      r.extended_count_word = {2'h0, d.count};
    end
    else
    begin
      r.count_word = {d.addr[17:16], d.count};
    end
    return r;
  endfunction : disp

  // build a control or information response
  function automatic bufcr_pkg::bufcr_resp_t ctrl(input logic [2:0] typ,
      input logic [7:0] code, input logic [7:0] tb, input logic [21:0] a,
      input logic ext, input logic mp);
    bufcr_pkg::bufcr_resp_t r;
    r = '0;
    r.command_type_byte = {5'h00, typ};
    r.tributary_address_byte = mp ? tb : 8'h01;
    r.low_address_word = a[15:0];
    if (ext)
    begin
      r.count_word = {2'h0, a[21:16], 8'h00};
      r.extended_code_byte = code;
    end
    else
    begin
      r.count_word = {6'h00, a[17:16], 8'h00};
      r.high_address_byte = code;
    end
    return r;
  endfunction : ctrl

  // handshakes: commands win over events, nothing taken while draining
  assign slot_free = !resp_valid_r || resp_ready;
  assign cmd_ready = (state_r == S_IDLE) && slot_free;
  assign ev_ready = (state_r == S_IDLE) && slot_free && !cmd_valid;
  assign take_cmd = cmd_valid && cmd_ready;
  assign take_ev = ev_valid && ev_ready;
  assign resp_valid = resp_valid_r;
  assign resp = resp_r;
  assign ext22_mode = ext22_r;

  // tributary index and incoming descriptor
  assign trib = take_cmd ? cmd.tributary_address_byte : ev.trib;
  assign trib_ok = (trib != 8'h00) && (trib <= 8'(NTRIB));
  assign idx = IW'(trib - 8'h01);
  assign pidx = halt_idx_r;
  always_comb
  begin
    cmd_desc.count = cmd.count_word[13:0];
    if (cmd.ext22)
      cmd_desc.addr = {cmd.high_address_byte[5:0], cmd.low_address_word};
    else
      cmd_desc.addr = {4'h0, cmd.count_word[15:14], cmd.low_address_word};
  end

  // decode one action per cycle
  always_comb
  begin
    state_nxt = state_r;
    resp_nxt = resp_r;
    load = 1'b0;
    push_rx = 1'b0;
    push_tx = 1'b0;
    push_pool = 1'b0;
    pop_rx = 1'b0;
    pop_tx = 1'b0;
    pop_pool = 1'b0;
    set_sent = 1'b0;
    clr_sent = 1'b0;
    retry_inc = 1'b0;
    retry_clr = 1'b0;
    halt_go = 1'b0;
    set_run = 1'b0;
    unique case (state_r)
      S_IDLE:
      begin
        if (take_cmd)
        begin
          unique case (cmd.kind)
            bufcr_pkg::CMD_BUF:
            begin
              if (cmd_desc.count == 14'h0000)
                load = 1'b1;
              else if (cmd.command_type_byte[2:0] == bufcr_pkg::BA_RX && trib == 8'h00)
              begin
                push_pool = (pool_cnt_r != (PW+1)'(POOL_DEPTH));
                load = !push_pool;
              end
              else if (cmd.command_type_byte[2:0] == bufcr_pkg::BA_RX && trib_ok)
              begin
                push_rx = (rx_cnt_r[idx] != (AW+1)'(DEPTH));
                load = !push_rx;
              end
              else if (cmd.command_type_byte[2:0] == bufcr_pkg::BA_TX && trib_ok)
              begin
                push_tx = (tx_cnt_r[idx] != (AW+1)'(DEPTH));
                load = !push_tx;
              end
              else
                load = 1'b1;
              resp_nxt = ctrl(bufcr_pkg::RESP_CTRL, bufcr_pkg::CODE_PROC_ERR, trib,
                              cmd_desc.addr, cmd.ext22, multipoint);
            end
            bufcr_pkg::CMD_HALT:
            begin
              halt_go = trib_ok || (trib == 8'h00);
              state_nxt = (trib == 8'h00) ? S_POOL : (trib_ok ? S_RX : S_IDLE);
            end
            bufcr_pkg::CMD_START:
              set_run = trib_ok;
            bufcr_pkg::CMD_POOL:
              set_run = 1'b0;
          endcase
        end
        else if (take_ev && trib_ok)
        begin
          unique case (ev.kind)
            bufcr_pkg::EV_RX_DONE:
            begin
              // private buffer first, pool only if this tributary may use it
              if (rx_cnt_r[idx] != '0)
              begin
                pop_rx = 1'b1;
                resp_nxt = disp(bufcr_pkg::DISP_RX_DONE, trib,
                  {rx_mem_r[idx][rx_head_r[idx]].addr, ev.count}, ext22_r, multipoint);
              end
              else if (pool_en_r[idx] && pool_cnt_r != '0)
              begin
                pop_pool = 1'b1;
                resp_nxt = disp(bufcr_pkg::DISP_RX_DONE, trib,
                  {pool_mem_r[pool_head_r].addr, ev.count}, ext22_r, multipoint);
              end
              load = pop_rx || pop_pool;
            end
            bufcr_pkg::EV_TX_START:
              set_sent = (tx_cnt_r[idx] != '0);
            bufcr_pkg::EV_TX_ACK:
            begin
              pop_tx = sent_r[idx];
              load = sent_r[idx];
              clr_sent = sent_r[idx];
              retry_clr = 1'b1;
              resp_nxt = disp(bufcr_pkg::DISP_TX_DONE, trib,
                              tx_mem_r[idx][tx_head_r[idx]], ext22_r, multipoint);
            end
            bufcr_pkg::EV_TX_NOACK:
            begin
              // message stays queued and sent; the host decides to stop
              retry_inc = sent_r[idx];
              load = sent_r[idx] && (retry_r[idx] == bufcr_pkg::RETRY_LIMIT - 3'h1);
              resp_nxt = ctrl(bufcr_pkg::RESP_CTRL, bufcr_pkg::CODE_TX_THRESH, trib,
                tx_mem_r[idx][tx_head_r[idx]].addr, ext22_r, multipoint);
            end
            bufcr_pkg::EV_START_RUN, bufcr_pkg::EV_MAINT:
            begin
              halt_go = run_r[idx];
              load = run_r[idx];
              state_nxt = run_r[idx] ? S_RX : S_IDLE;
              resp_nxt = ctrl(bufcr_pkg::RESP_CTRL, (ev.kind == bufcr_pkg::EV_MAINT) ?
                bufcr_pkg::CODE_MAINT_RUN : bufcr_pkg::CODE_START_RUN, trib, 22'h000000,
                ext22_r, multipoint);
            end
            default:
              load = 1'b0;
          endcase
        end
      end
      S_RX:
      begin
        // private receive buffers only; the pool stays put
        if (rx_cnt_r[pidx] == '0)
          state_nxt = S_TX;
        else if (slot_free)
        begin
          pop_rx = 1'b1;
          load = 1'b1;
          resp_nxt = disp(bufcr_pkg::DISP_RX_UNUSED, 8'(pidx) + 8'h01,
                          rx_mem_r[pidx][rx_head_r[pidx]], ext22_r, multipoint);
        end
      end
      S_TX:
      begin
        if (tx_cnt_r[pidx] == '0)
          state_nxt = S_IDLE;
        else if (slot_free)
        begin
          pop_tx = 1'b1;
          load = 1'b1;
          clr_sent = 1'b1;
          // only the head can be on the wire
          resp_nxt = disp(sent_r[pidx] ? bufcr_pkg::DISP_TX_NOACK :
            bufcr_pkg::DISP_TX_NOTSENT, 8'(pidx) + 8'h01,
            tx_mem_r[pidx][tx_head_r[pidx]], ext22_r, multipoint);
        end
      end
      S_POOL:
      begin
        if (pool_cnt_r == '0)
          state_nxt = S_DONE;
        else if (slot_free)
        begin
          pop_pool = 1'b1;
          load = 1'b1;
          resp_nxt = disp(bufcr_pkg::DISP_RX_UNUSED, 8'h00,
                          pool_mem_r[pool_head_r], ext22_r, multipoint);
        end
      end
      S_DONE:
      begin
        if (slot_free)
        begin
          load = 1'b1;
          state_nxt = S_IDLE;
          resp_nxt = ctrl(bufcr_pkg::RESP_INFO, bufcr_pkg::CODE_POOL_DONE, 8'h00,
                          22'h000000, ext22_r, multipoint);
        end
      end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // drain sequencer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= S_IDLE;
      halt_idx_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (halt_go)
        halt_idx_r <= idx;
    end
  end

  // response register holds until taken
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid_r <= 1'b0;
      resp_r <= '0;
    end
    else if (slot_free)
    begin
      resp_valid_r <= load;
      if (load)
        resp_r <= resp_nxt;
    end
  end

  // address width latched from each assignment
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ext22_r <= bufcr_pkg::EXT22_RST;
    else if (take_cmd && cmd.kind == bufcr_pkg::CMD_BUF)
      ext22_r <= cmd.ext22;
  end

  // common pool queue
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pool_head_r <= '0;
      pool_cnt_r <= '0;
    end
    else
    begin
      if (push_pool)
        pool_mem_r[PW'(pool_head_r + pool_cnt_r[PW-1:0])] <= cmd_desc;
      if (pop_pool)
        pool_head_r <= PW'(pool_head_r + 1'b1);
      pool_cnt_r <= (PW+1)'(pool_cnt_r + push_pool - pop_pool);
    end
  end

  // per-tributary queues and state
  for (genvar g = 0; g < NTRIB; g++)
  begin : g_trib
    wire logic hit = (idx == IW'(g));
    wire logic phit = (pidx == IW'(g)) && (state_r != S_IDLE);
    wire logic prx = pop_rx && (phit || (state_r == S_IDLE && hit));
    wire logic ptx = pop_tx && (phit || (state_r == S_IDLE && hit));
    // a tributary zero halt drains the pool only, never a tributary's own state
    wire logic hlt = halt_go && hit && trib_ok;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        rx_head_r[g] <= '0;
        rx_cnt_r[g] <= '0;
        tx_head_r[g] <= '0;
        tx_cnt_r[g] <= '0;
        run_r[g] <= 1'b0;
        pool_en_r[g] <= 1'b0;
        sent_r[g] <= 1'b0;
        retry_r[g] <= '0;
      end
      else
      begin
        if (push_rx && hit)
          rx_mem_r[g][AW'(rx_head_r[g] + rx_cnt_r[g][AW-1:0])] <= cmd_desc;
        if (push_tx && hit)
          tx_mem_r[g][AW'(tx_head_r[g] + tx_cnt_r[g][AW-1:0])] <= cmd_desc;
        if (prx)
          rx_head_r[g] <= AW'(rx_head_r[g] + 1'b1);
        if (ptx)
          tx_head_r[g] <= AW'(tx_head_r[g] + 1'b1);
        rx_cnt_r[g] <= (AW+1)'(rx_cnt_r[g] + (push_rx && hit) - prx);
        tx_cnt_r[g] <= (AW+1)'(tx_cnt_r[g] + (push_tx && hit) - ptx);
        if (take_cmd && cmd.kind == bufcr_pkg::CMD_POOL && hit && trib_ok)
          pool_en_r[g] <= cmd.pool_en;
        if (set_run && hit)
          run_r[g] <= 1'b1;
        else if (hlt)
          run_r[g] <= 1'b0;
        if (set_sent && hit)
          sent_r[g] <= 1'b1;
        else if (clr_sent && (hit || phit))
          sent_r[g] <= 1'b0;
        if ((retry_clr && hit) || hlt || (load && retry_inc && hit))
          retry_r[g] <= '0;
        else if (retry_inc && hit)
          retry_r[g] <= 3'(retry_r[g] + 3'h1);
      end
    end
  end

  // checks
  sequence s_halt_start;
    state_r == S_IDLE ##1 state_r != S_IDLE;
  endsequence
  sequence s_drained;
    ##[1:200] state_r == S_IDLE;
  endsequence

  a_zero_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_cmd && cmd.kind == bufcr_pkg::CMD_BUF && cmd.count_word[13:0] == 14'h0000
    |=> resp_valid_r && resp_r.command_type_byte[2:0] == bufcr_pkg::RESP_CTRL)
    else $error("zero count not refused");
  a_tx_trib_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_cmd && cmd.kind == bufcr_pkg::CMD_BUF && trib == 8'h00
    && cmd.command_type_byte[2:0] == bufcr_pkg::BA_TX
    |=> resp_valid_r && resp_r.command_type_byte[2:0] == bufcr_pkg::RESP_CTRL
    && $stable(pool_cnt_r))
    else $error("transmit to tributary zero accepted");
  a_pool_join: assert property (@(posedge ref_clk) disable iff (!rst_n)
    push_pool && !pop_pool |=> pool_cnt_r == $past(pool_cnt_r) + 1'b1)
    else $error("pool buffer lost");
  a_ext_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_cmd && cmd.kind == bufcr_pkg::CMD_BUF |=> ext22_r == $past(cmd.ext22))
    else $error("width bit not latched");
  a_resp_type: assert property (@(posedge ref_clk) disable iff (!rst_n)
    resp_valid_r |-> resp_r.command_type_byte[7:3] == 5'h00)
    else $error("response type outside low bits");
  a_p2p_trib: assert property (@(posedge ref_clk) disable iff (!rst_n)
    resp_valid_r && !$past(multipoint) && $rose(resp_valid_r)
    |-> resp_r.tributary_address_byte == 8'h01)
    else $error("point-to-point tributary byte not one");
  a_halt_drain: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_halt_start |-> s_drained)
    else $error("halt drain did not finish");
  a_ack_sent: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load && resp_nxt.command_type_byte[2:0] == bufcr_pkg::DISP_TX_DONE
    |-> take_ev && ev.kind == bufcr_pkg::EV_TX_ACK && sent_r[idx])
    else $error("transmit complete without acknowledgement");
  a_resp_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    resp_valid_r && !resp_ready |=> resp_valid_r && $stable(resp_r))
    else $error("response changed while waiting");

endmodule : bufcr_core

/* File: tb/bufcr_host_model.sv */
/*
  bufcr_host_model: host program side that drains responses, prompt or stalling.
  Assumes the block's response port on ref_clk; the bench reads got and last.
*/
module bufcr_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // stall control from the bench
  input wire logic slow,
  // response port
  input wire logic resp_valid,
  output logic resp_ready,
  input wire bufcr_pkg::bufcr_resp_t resp,
  // captured response, got pulses once per take
  output logic got,
  output bufcr_pkg::bufcr_resp_t last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  // slow host takes one slot in four, so responses must wait in the block
  assign resp_ready = !slow || (div_r == 2'h3);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end
  // every taken response is kept in last until the next take for judging
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      got <= 1'b0;
      last <= '0;
    end
    else
    begin
      got <= resp_valid && resp_ready;
      if (resp_valid && resp_ready)
        last <= resp;
    end
  end
endmodule : bufcr_host_model

/* File: tb/buffer_command_response_bench.sv */
/*
  buffer_command_response_bench: directed scenarios for bufcr_core.
  Assumes bufcr_pkg and bufcr_host_model; inputs change 1 ns after edges.
*/
module buffer_command_response_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic multipoint = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  bufcr_pkg::bufcr_cmd_t cmd = '0;
  logic ev_valid = 1'b0;
  logic ev_ready;
  bufcr_pkg::bufcr_ev_t ev = '0;
  logic resp_valid;
  logic resp_ready;
  bufcr_pkg::bufcr_resp_t resp;
  logic ext22_mode;
  logic slow = 1'b0;
  logic got;
  bufcr_pkg::bufcr_resp_t last;
  int errors = 0;
  int samples_checked = 0;

  // 125 MHz
  always #4 ref_clk = ~ref_clk;

  bufcr_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .multipoint(multipoint),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .ev_valid(ev_valid),
    .ev_ready(ev_ready), .ev(ev), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp(resp), .ext22_mode(ext22_mode));
  bufcr_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp), .got(got),
    .last(last));

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic give_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // one command, held until the edge where cmd_ready is high
  task automatic send_cmd(input bufcr_pkg::bufcr_cmd_kind_t k, input logic [2:0] typ,
    input logic [7:0] trib, input logic [15:0] low, input logic [15:0] cw,
    input logic [7:0] hi, input logic x22, input logic pen);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    cmd = '{k, {5'h0, typ}, trib, low, cw, hi, x22, pen};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n < 50, "command stuck");
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
  endtask : send_cmd

  // one buffer per command, count word carries upper address and count
  task automatic send_buf(input logic [2:0] typ, input logic [7:0] trib,
    input logic [15:0] low, input logic [15:0] cw);
    send_cmd(bufcr_pkg::CMD_BUF, typ, trib, low, cw, 8'h00, 1'b0, 1'b0);
  endtask : send_buf

  task automatic send_ev(input bufcr_pkg::bufcr_ev_kind_t k, input logic [7:0] trib,
    input logic [13:0] cnt);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    ev = '{k, trib, cnt};
    ev_valid = 1'b1;
    while (ev_ready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n < 50, "event stuck");
    @(posedge ref_clk);
    #1;
    ev_valid = 1'b0;
  endtask : send_ev

  // wait a bounded time for the next taken response, then judge type and tributary
  task automatic expect_resp(input logic [2:0] typ, input logic [7:0] trib);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (got !== 1'b1 && n < 60);
    check(got === 1'b1, "response missing");
    check(last.command_type_byte[2:0] === typ, "response type");
    check(last.tributary_address_byte === trib, "tributary byte");
  endtask : expect_resp

  task automatic expect_none(input int cycles);
    repeat (cycles)
    begin
      @(posedge ref_clk);
      #1;
      check(got !== 1'b1, "unexpected response");
    end
  endtask : expect_none

  task automatic addr_is(input logic [15:0] low, input logic [15:0] cw);
    check(last.low_address_word === low && last.count_word === cw, "address or count");
  endtask : addr_is

  task automatic t_errors;
    send_buf(bufcr_pkg::BA_RX, 8'd1, 16'h1000, 16'h0000);
    expect_resp(bufcr_pkg::RESP_CTRL, 8'd1);
    check(last.high_address_byte === bufcr_pkg::CODE_PROC_ERR, "zero count");
    send_buf(bufcr_pkg::BA_TX, 8'd0, 16'h1100, 16'h0005);
    expect_resp(bufcr_pkg::RESP_CTRL, 8'd0);
    check(last.high_address_byte === bufcr_pkg::CODE_PROC_ERR, "tx to zero");
    // fill tributary four's private queue, the next assignment is refused
    repeat (4) send_buf(bufcr_pkg::BA_RX, 8'd4, 16'h1200, 16'h0004);
    expect_none(2);
    send_buf(bufcr_pkg::BA_RX, 8'd4, 16'h1300, 16'h0004);
    expect_resp(bufcr_pkg::RESP_CTRL, 8'd4);
    check(last.high_address_byte === bufcr_pkg::CODE_PROC_ERR, "full queue");
  endtask : t_errors

  task automatic t_rx_private;
    send_buf(bufcr_pkg::BA_RX, 8'd1, 16'h2340, {2'b10, 14'h0040});
    expect_none(4);
    send_ev(bufcr_pkg::EV_RX_DONE, 8'd1, 14'h3fff);
    expect_resp(bufcr_pkg::DISP_RX_DONE, 8'd1);
    addr_is(16'h2340, {2'b10, 14'h3fff});
  endtask : t_rx_private

  task automatic t_tx_halt;
    send_buf(bufcr_pkg::BA_RX, 8'd2, 16'h0008, {2'b01, 14'h0008});
    send_buf(bufcr_pkg::BA_TX, 8'd2, 16'h3000, {2'b01, 14'h0010});
    send_buf(bufcr_pkg::BA_TX, 8'd2, 16'h3100, {2'b11, 14'h0020});
    send_ev(bufcr_pkg::EV_TX_START, 8'd2, 14'h0);
    expect_none(3);
    send_ev(bufcr_pkg::EV_TX_ACK, 8'd2, 14'h0);
    expect_resp(bufcr_pkg::DISP_TX_DONE, 8'd2);
    addr_is(16'h3000, {2'b01, 14'h0010});
    send_buf(bufcr_pkg::BA_TX, 8'd2, 16'h3200, {2'b00, 14'h0030});
    send_ev(bufcr_pkg::EV_TX_START, 8'd2, 14'h0);
    repeat (6) send_ev(bufcr_pkg::EV_TX_NOACK, 8'd2, 14'h0);
    expect_none(2);
    send_ev(bufcr_pkg::EV_TX_NOACK, 8'd2, 14'h0);
    expect_resp(bufcr_pkg::RESP_CTRL, 8'd2);
    check(last.high_address_byte === bufcr_pkg::CODE_TX_THRESH, "threshold code");
    check(last.low_address_word === 16'h3100, "threshold addr");
    check(last.count_word[9:8] === 2'b11, "threshold upper");
    // stalling host during the halt drain
    slow = 1'b1;
    send_cmd(bufcr_pkg::CMD_HALT, 3'h0, 8'd2, 16'h0, 16'h0, 8'h0, 1'b0, 1'b0);
    expect_resp(bufcr_pkg::DISP_RX_UNUSED, 8'd2);
    addr_is(16'h0008, {2'b01, 14'h0008});
    expect_resp(bufcr_pkg::DISP_TX_NOACK, 8'd2);
    addr_is(16'h3100, {2'b11, 14'h0020});
    expect_resp(bufcr_pkg::DISP_TX_NOTSENT, 8'd2);
    addr_is(16'h3200, {2'b00, 14'h0030});
    expect_none(8);
    slow = 1'b0;
  endtask : t_tx_halt

  task automatic t_pool;
    send_cmd(bufcr_pkg::CMD_POOL, 3'h0, 8'd3, 16'h0, 16'h0, 8'h0, 1'b0, 1'b1);
    send_buf(bufcr_pkg::BA_RX, 8'd0, 16'h4000, 16'h0020);
    send_buf(bufcr_pkg::BA_RX, 8'd0, 16'h4100, 16'h0030);
    send_ev(bufcr_pkg::EV_RX_DONE, 8'd3, 14'h0011);
    expect_resp(bufcr_pkg::DISP_RX_DONE, 8'd3);
    addr_is(16'h4000, 16'h0011);
    send_ev(bufcr_pkg::EV_RX_DONE, 8'd1, 14'h0011);
    expect_none(4);
    send_cmd(bufcr_pkg::CMD_HALT, 3'h0, 8'd0, 16'h0, 16'h0, 8'h0, 1'b0, 1'b0);
    expect_resp(bufcr_pkg::DISP_RX_UNUSED, 8'd0);
    addr_is(16'h4100, 16'h0030);
    expect_resp(bufcr_pkg::RESP_INFO, 8'd0);
    check(last.high_address_byte === bufcr_pkg::CODE_POOL_DONE, "pool done code");
  endtask : t_pool

  task automatic t_p2p_ext;
    multipoint = 1'b0;
    send_cmd(bufcr_pkg::CMD_BUF, bufcr_pkg::BA_RX, 8'd3, 16'h5000, 16'h0040, 8'h2a,
      1'b1, 1'b0);
    check(ext22_mode === 1'b1, "width bit not kept");
    send_ev(bufcr_pkg::EV_RX_DONE, 8'd3, 14'h0021);
    expect_resp(bufcr_pkg::DISP_RX_DONE, 8'd1);
    check(last.low_address_word === 16'h5000, "ext low");
    check(last.high_address_byte === 8'h2a, "ext upper");
    check(last.extended_count_word === 16'h0021, "ext count");
    send_cmd(bufcr_pkg::CMD_START, 3'h0, 8'd3, 16'h0, 16'h0, 8'h0, 1'b0, 1'b0);
    send_ev(bufcr_pkg::EV_START_RUN, 8'd3, 14'h0);
    expect_resp(bufcr_pkg::RESP_CTRL, 8'd1);
    check(last.extended_code_byte === bufcr_pkg::CODE_START_RUN, "start code");
    // halted now, so a second start message changes nothing
    send_ev(bufcr_pkg::EV_START_RUN, 8'd3, 14'h0);
    expect_none(4);
    send_cmd(bufcr_pkg::CMD_START, 3'h0, 8'd3, 16'h0, 16'h0, 8'h0, 1'b0, 1'b0);
    send_ev(bufcr_pkg::EV_MAINT, 8'd3, 14'h0);
    expect_resp(bufcr_pkg::RESP_CTRL, 8'd1);
    check(last.extended_code_byte === bufcr_pkg::CODE_MAINT_RUN, "maint code");
    check(ext22_mode === 1'b1, "width bit lost");
  endtask : t_p2p_ext

  // watchdog, far beyond the few hundred cycles the scenarios need
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1;
    check(resp_valid === 1'b0 && ext22_mode === 1'b0, "reset values");
    rst_n = 1'b1;
    t_errors();
    t_rx_private();
    t_tx_halt();
    t_pool();
    t_p2p_ext();
    give_verdict();
  end
endmodule : buffer_command_response_bench
